//--- rifc_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------
// shared constants of the format and interrupt control block
// ----------------------------------------------------------------------
package rifc_pkg;
    // register word indices; one 32-bit word per register
    localparam logic [7:0] RIFC_IDX_FMT = 8'h0B;
    localparam logic [7:0] RIFC_IDX_FLAGS = 8'h0C;
    // sticky status and mask sit past the clock's own control registers
    localparam logic [7:0] RIFC_IDX_IRQ_STS = 8'h0E;
    localparam logic [7:0] RIFC_IDX_IRQ_MASK = 8'h0F;
    // byte address on the host bus is four times the index
    localparam logic [7:0] RIFC_ADDR_FMT = {RIFC_IDX_FMT[5:0], 2'h0};
    localparam logic [7:0] RIFC_ADDR_FLAGS = {RIFC_IDX_FLAGS[5:0], 2'h0};
    localparam logic [7:0] RIFC_ADDR_IRQ_STS = {RIFC_IDX_IRQ_STS[5:0], 2'h0};
    localparam logic [7:0] RIFC_ADDR_IRQ_MASK = {RIFC_IDX_IRQ_MASK[5:0], 2'h0};
    // control register field positions
    localparam int RIFC_HOUR_BIT = 1;
    localparam int RIFC_DATA_BIT = 2;
    localparam int RIFC_ZERO_BIT = 3;
    localparam int RIFC_UPD_EN_BIT = 4;
    localparam int RIFC_ALM_EN_BIT = 5;
    localparam int RIFC_PER_EN_BIT = 6;
    // flag register field positions
    localparam int RIFC_UPD_FLAG_BIT = 4;
    localparam int RIFC_ALM_FLAG_BIT = 5;
    localparam int RIFC_PER_FLAG_BIT = 6;
    localparam int RIFC_REQ_FLAG_BIT = 7;
    // event index inside the three-bit event vectors
    localparam int RIFC_EV_UPD = 0;
    localparam int RIFC_EV_ALM = 1;
    localparam int RIFC_EV_PER = 2;
    localparam int RIFC_NUM_EV = 3;
    // values after reset
    localparam logic RIFC_FMT_BIT_RST = 1'b0;
    localparam logic [2:0] RIFC_EN_RST = 3'h0;
    localparam logic [2:0] RIFC_MASK_RST = 3'h0;
    localparam logic RIFC_TAP_RST = 1'b0;
    localparam logic [31:0] RIFC_RDATA_RST = 32'h0000_0000;
    // bus encodings
    localparam logic [2:0] RIFC_HSIZE_WORD = 3'h2;
    localparam logic RIFC_HRESP_OKAY = 1'b0;
endpackage : rifc_pkg
`default_nettype wire

//--- rifc_flag.sv
`default_nettype none
// ----------------------------------------------------------------------
// one sticky event flag, set wins over clear
// ----------------------------------------------------------------------
module rifc_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    // an event in the clearing cycle must survive, so set is tested first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule : rifc_flag
`default_nettype wire

//--- rifc_top.sv
`default_nettype none
// Contract
// R1: hour format bit: 1 is 24h, 0 12h
// R2: data mode bit: 1 binary, 0 BCD
// R3: control bit 3 always reads zero
// R4: update enable raises update interrupt; reset clears
// R5: alarm enable raises interrupt on matching update
// R6: periodic enable raises interrupt at tap rate
// R7: update flag set on update, read clears
// R8: alarm flag set on match, read clears
// R9: periodic flag set on tap transition
// R10: request flag when any enabled pair set
// R11: request flag mirrors low interrupt pin
// R12: pin low on event, released by read
// R13: software rereads status until no request
// R14: status low nibble zero, writes ignored
module rifc_top
    import rifc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pwr_on_rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // events from the rest of the clock
    input wire logic time_update,
    input wire logic alarm_match,
    input wire logic periodic_tap,
    // format selections seen by the time keeping logic
    output logic hour_format_select,
    output logic binary_data_mode,
    // interrupt outputs
    output logic rtc_irq_n,
    output logic irq
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // full address compare; upper bits must be zero, no aliasing
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == {24'h00_0000, off});
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------

    logic take; // address phase accepted this edge
    logic rd_take; // accepted read
    logic wr_take; // accepted write
    logic wr_pend; // write data phase in progress
    logic [31:0] wr_addr; // address held for the write data phase
    logic [2:0] int_en; // update, alarm, periodic enables
    logic [2:0] ev; // raw events this cycle
    logic [2:0] flag; // clear-on-read event flags
    logic [2:0] sts; // write-one-to-clear sticky status
    logic [2:0] mask; // interrupt mask
    logic [2:0] sts_clr; // write-one-to-clear strobes
    logic flags_rd; // read of the flag register taken
    logic tap_q; // previous level of the divider tap
    logic irq_request_flag; // any enabled event pending
    logic update_end_int_enable;
    logic alarm_int_enable;
    logic periodic_int_enable;
    logic update_end_flag;
    logic alarm_flag;
    logic periodic_flag;
    logic [7:0] fmt_view; // control register as software reads it
    logic [7:0] flag_view; // flag register as software reads it
    logic [31:0] next_rdata; // read mux output

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------

    // zero wait state slave, every answer is okay
    assign hreadyout = 1'b1;
    assign hresp = RIFC_HRESP_OKAY;

    // only whole word transfers are acted on; others finish silently
    assign take = hsel && htrans[1] && hready && (hsize == RIFC_HSIZE_WORD);
    assign rd_take = take && !hwrite;
    assign wr_take = take && hwrite;

    // write address is held until the data phase brings hwdata
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= wr_take;
            if (wr_take) begin
                wr_addr <= haddr;
            end
        end
    end

    // ------------------------------------------------------------------
    // format bits
    // ------------------------------------------------------------------

    // bus reset leaves the formats alone; only power-on clears them
    always_ff @(posedge clk or negedge pwr_on_rst_n) begin
        if (!pwr_on_rst_n) begin
            hour_format_select <= RIFC_FMT_BIT_RST;
            binary_data_mode <= RIFC_FMT_BIT_RST;
        end else if (wr_pend && reg_hit(wr_addr, RIFC_ADDR_FMT)) begin
            hour_format_select <= hwdata[RIFC_HOUR_BIT]; // [R1]
            binary_data_mode <= hwdata[RIFC_DATA_BIT]; // [R2]
        end
    end

    // ------------------------------------------------------------------
    // interrupt enables
    // ------------------------------------------------------------------

    // enables are cleared by the bus reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_en <= RIFC_EN_RST; // [R4] [R5] [R6]
        end else if (wr_pend && reg_hit(wr_addr, RIFC_ADDR_FMT)) begin
            int_en[RIFC_EV_UPD] <= hwdata[RIFC_UPD_EN_BIT]; // [R4]
            int_en[RIFC_EV_ALM] <= hwdata[RIFC_ALM_EN_BIT]; // [R5]
            int_en[RIFC_EV_PER] <= hwdata[RIFC_PER_EN_BIT]; // [R6]
        end
    end

    assign update_end_int_enable = int_en[RIFC_EV_UPD];
    assign alarm_int_enable = int_en[RIFC_EV_ALM];
    assign periodic_int_enable = int_en[RIFC_EV_PER];

    // ------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------

    // tap level from the divider, same clock, so no synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_q <= RIFC_TAP_RST;
        end else begin
            tap_q <= periodic_tap;
        end
    end

    // alarm compare is only meaningful right after an update
    assign ev[RIFC_EV_UPD] = time_update; // [R7]
    assign ev[RIFC_EV_ALM] = time_update && alarm_match; // [R5] [R8]
    // rising edge only: one flag per full tap period
    assign ev[RIFC_EV_PER] = periodic_tap && !tap_q; // [R9]

    // ------------------------------------------------------------------
    // flags and sticky status
    // ------------------------------------------------------------------

    // clear at the accepting edge, so hrdata holds the pre-clear view
    assign flags_rd = rd_take && reg_hit(haddr, RIFC_ADDR_FLAGS);

    // write-one-to-clear strobes of the sticky status register
    assign sts_clr = (wr_pend && reg_hit(wr_addr, RIFC_ADDR_IRQ_STS)) ?
                     hwdata[2:0] : 3'h0;

    // a second event of the same kind before the read merges here
    generate
        for (genvar i = 0; i < RIFC_NUM_EV; i++) begin : g_flag
            // flags are set regardless of enables
            rifc_flag u_flag (
                .clk(clk),
                .rst_n(rst_n),
                .set(ev[i]),
                .clr(flags_rd),
                .q(flag[i])
            ); // [R7] [R8] [R9] [R12]
            // sticky copy for the system interrupt line
            rifc_flag u_sts (
                .clk(clk),
                .rst_n(rst_n),
                .set(ev[i]),
                .clr(sts_clr[i]),
                .q(sts[i])
            );
        end
    endgenerate

    assign update_end_flag = flag[RIFC_EV_UPD];
    assign alarm_flag = flag[RIFC_EV_ALM];
    assign periodic_flag = flag[RIFC_EV_PER];

    // ------------------------------------------------------------------
    // interrupt request and outputs
    // ------------------------------------------------------------------

    // any single enabled pair is enough to request
    assign irq_request_flag = |(int_en & flag); // [R10]
    // pin is the inverse of the request flag at all times
    assign rtc_irq_n = !irq_request_flag; // [R11] [R12]

    // interrupt mask, cleared by reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= RIFC_MASK_RST;
        end else if (wr_pend && reg_hit(wr_addr, RIFC_ADDR_IRQ_MASK)) begin
            mask <= hwdata[2:0];
        end
    end

    // level output while an unmasked sticky bit is set
    assign irq = |(sts & mask);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // set mode and daylight bits are outside this block and read zero
    always_comb begin
        fmt_view = 8'h00;
        fmt_view[RIFC_HOUR_BIT] = hour_format_select;
        fmt_view[RIFC_DATA_BIT] = binary_data_mode;
        fmt_view[RIFC_ZERO_BIT] = 1'b0; // [R3]
        fmt_view[RIFC_UPD_EN_BIT] = update_end_int_enable;
        fmt_view[RIFC_ALM_EN_BIT] = alarm_int_enable;
        fmt_view[RIFC_PER_EN_BIT] = periodic_int_enable;
    end

    // low nibble of the flag view is constant zero
    always_comb begin
        flag_view = 8'h00; // [R14]
        flag_view[RIFC_UPD_FLAG_BIT] = update_end_flag;
        flag_view[RIFC_ALM_FLAG_BIT] = alarm_flag;
        flag_view[RIFC_PER_FLAG_BIT] = periodic_flag;
        flag_view[RIFC_REQ_FLAG_BIT] = irq_request_flag; // [R11]
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_hit(haddr, RIFC_ADDR_FMT)) begin
            next_rdata = {24'h00_0000, fmt_view};
        end else if (reg_hit(haddr, RIFC_ADDR_FLAGS)) begin
            next_rdata = {24'h00_0000, flag_view};
        end else if (reg_hit(haddr, RIFC_ADDR_IRQ_STS)) begin
            next_rdata = {29'h000_0000, sts};
        end else if (reg_hit(haddr, RIFC_ADDR_IRQ_MASK)) begin
            next_rdata = {29'h000_0000, mask};
        end
    end

    // read data registered at the address edge, valid in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= RIFC_RDATA_RST;
        end else if (rd_take) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // accepted read of the flag register
    sequence s_flags_read;
        rd_take && reg_hit(haddr, RIFC_ADDR_FLAGS);
    endsequence

    // accepted read of the control register
    sequence s_fmt_read;
        rd_take && reg_hit(haddr, RIFC_ADDR_FMT);
    endsequence

    // write data phase to the flag register
    sequence s_flags_write;
        wr_pend && reg_hit(wr_addr, RIFC_ADDR_FLAGS);
    endsequence

    // write data phase to the control register
    sequence s_fmt_write;
        wr_pend && reg_hit(wr_addr, RIFC_ADDR_FMT);
    endsequence

    a_hour_fmt_wr: assert property ( // [R1]
        s_fmt_write |=> hour_format_select == $past(hwdata[RIFC_HOUR_BIT]))
        else $error("hour format not taken from write");

    a_data_mode_wr: assert property ( // [R2]
        s_fmt_write |=> binary_data_mode == $past(hwdata[RIFC_DATA_BIT]))
        else $error("data mode not taken from write");

    a_sqw_bit_zero: assert property ( // [R3]
        s_fmt_read |=> hrdata[RIFC_ZERO_BIT] == 1'b0)
        else $error("control bit 3 read as one");

    a_upd_irq_low: assert property ( // [R4]
        time_update && update_end_int_enable && !flags_rd |=> !rtc_irq_n)
        else $error("update interrupt not raised");

    a_alarm_irq_low: assert property ( // [R5]
        time_update && alarm_match && alarm_int_enable && !flags_rd
        |=> alarm_flag && !rtc_irq_n)
        else $error("alarm interrupt not raised");

    a_per_irq_low: assert property ( // [R6]
        $rose(periodic_tap) && periodic_int_enable && !flags_rd
        |=> periodic_flag && !rtc_irq_n)
        else $error("periodic interrupt not raised");

    a_upd_flag_set: assert property ( // [R7]
        time_update |=> update_end_flag)
        else $error("update flag not set");

    a_flag_rd_clr: assert property ( // [R7] [R8] [R9] [R12]
        s_flags_read ##0 (ev == 3'h0) |=> flag == 3'h0 && rtc_irq_n)
        else $error("flags not cleared by read");

    a_rd_shows_old: assert property ( // [R12]
        s_flags_read ##0 (flag != 3'h0)
        |=> hrdata[6:4] == $past(flag))
        else $error("read lost pending flags");

    a_irq_any_pair: assert property ( // [R10] [R11]
        (update_end_flag && update_end_int_enable) ##0 !alarm_int_enable
        |-> !rtc_irq_n && irq_request_flag)
        else $error("single enabled pair did not request");

    a_no_irq_quiet: assert property ( // [R4] [R10]
        int_en == 3'h0 |-> rtc_irq_n)
        else $error("pin low with all enables off");

    a_status_nibble: assert property ( // [R14] [R11]
        s_flags_read |=> hrdata[3:0] == 4'h0
        && hrdata[RIFC_REQ_FLAG_BIT] == !$past(rtc_irq_n))
        else $error("flag read view wrong");

    a_flag_wr_none: assert property ( // [R14]
        s_flags_write ##0 (ev == 3'h0) ##0 !flags_rd |=> $stable(flag))
        else $error("write changed a flag");

endmodule : rifc_top
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb
    import rifc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------------------------------------------------
    // clock, reset and bus signals
    // --------------------------------------------------------------
    logic clk = 1'b0; // 20 MHz bench clock
    logic rst_n = 1'b0; // block reset, active low
    logic pwr_on_rst_n = 1'b0; // format reset, active low
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready_bus; // single slave: its ready is the bus ready
    wire logic hresp;
    wire logic [31:0] hrdata;
    logic time_update = 1'b0; // one-cycle update pulse
    logic alarm_match = 1'b0; // compare result, looked at with update
    logic periodic_tap = 1'b0; // selected divider tap level
    wire logic hour_format_select;
    wire logic binary_data_mode;
    wire logic rtc_irq_n;
    wire logic irq;
    int n_errors = 0; // mismatches seen
    int tests_run = 0; // comparisons made
    logic [7:0] wv [4] = '{8'hFF, 8'h02, 8'h04, 8'h00}; // control writes
    logic [7:0] ev [4] = '{8'h76, 8'h02, 8'h04, 8'h00}; // expected reads

    always #25 clk = ~clk;

    rifc_top rifc_top_i (.clk(clk), .rst_n(rst_n),
        .pwr_on_rst_n(pwr_on_rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready_bus), .hwdata(hwdata), .hreadyout(hready_bus),
        .hresp(hresp), .hrdata(hrdata), .time_update(time_update),
        .alarm_match(alarm_match), .periodic_tap(periodic_tap),
        .hour_format_select(hour_format_select),
        .binary_data_mode(binary_data_mode), .rtc_irq_n(rtc_irq_n),
        .irq(irq));

    // --------------------------------------------------------------
    // compare tasks and the closing task
    // --------------------------------------------------------------
    task automatic chk_reg(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // bus access: address phase held until ready, then data phase
    // --------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= RIFC_HSIZE_WORD;
        @(posedge clk);
        while (hready_bus !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready_bus !== 1'b1) @(posedge clk);
        q = hrdata; // read data taken at the edge ending the data phase
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, q);
        chk_reg(nm, e, q);
    endtask

    // update event, with or without an alarm match in the same cycle
    task automatic upd(input logic m);
        @(posedge clk);
        time_update <= 1'b1;
        alarm_match <= m;
        @(posedge clk);
        time_update <= 1'b0;
        alarm_match <= 1'b0;
        #1;
    endtask

    // move the divider tap to a new level
    task automatic tap(input logic v);
        @(posedge clk);
        periodic_tap <= v;
        @(posedge clk);
        #1;
    endtask

    // --------------------------------------------------------------
    // watchdog: the tests need well under a thousand cycles
    // --------------------------------------------------------------
    initial begin
        #(50 * 5000);
        n_errors++;
        $display("watchdog expired");
        conclude();
    end

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        pwr_on_rst_n <= 1'b1;
        // reset values of the control and flag registers, the interrupt pin and hresp
        rchk("ctrl_rst", RIFC_ADDR_FMT, 32'h0000_0000);
        rchk("flags_rst", RIFC_ADDR_FLAGS, 32'h0000_0000);
        chk_pin("irq_n_rst", 1'b1, rtc_irq_n);
        chk_pin("hresp", RIFC_HRESP_OKAY, hresp);
        $display("test reset done");
        // control bits, bit 3 and spare bits read zero
        for (int i = 0; i < 4; i++) begin
            wr(RIFC_ADDR_FMT, {24'h00_0000, wv[i]});
            rchk("ctrl", RIFC_ADDR_FMT, {24'h00_0000, ev[i]});
            chk_pin("hour", ev[i][RIFC_HOUR_BIT], hour_format_select);
            chk_pin("bin", ev[i][RIFC_DATA_BIT], binary_data_mode);
        end
        // block reset mid-run keeps formats, clears enables
        wr(RIFC_ADDR_FMT, 32'h0000_0076);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl_rst2", RIFC_ADDR_FMT, 32'h0000_0006);
        chk_pin("hour_kept", 1'b1, hour_format_select);
        $display("test control done");
        // update-ended interrupt enabled, then disabled
        wr(RIFC_ADDR_FMT, 32'h0000_0010);
        upd(1'b0);
        chk_pin("irq_n_upd", 1'b0, rtc_irq_n);
        rchk("flags_upd", RIFC_ADDR_FLAGS, 32'h0000_0090);
        chk_pin("irq_n_rel", 1'b1, rtc_irq_n);
        rchk("flags_clr", RIFC_ADDR_FLAGS, 32'h0000_0000);
        wr(RIFC_ADDR_FMT, 32'h0000_0000);
        upd(1'b0);
        chk_pin("irq_n_off", 1'b1, rtc_irq_n);
        rchk("flags_noen", RIFC_ADDR_FLAGS, 32'h0000_0010);
        $display("test update done");
        // alarm: match raises, update without match does not
        wr(RIFC_ADDR_FMT, 32'h0000_0020);
        upd(1'b1);
        chk_pin("irq_n_alm", 1'b0, rtc_irq_n);
        rchk("flags_alm", RIFC_ADDR_FLAGS, 32'h0000_00B0);
        upd(1'b0);
        chk_pin("irq_n_nomatch", 1'b1, rtc_irq_n);
        rchk("flags_nomatch", RIFC_ADDR_FLAGS, 32'h0000_0010);
        $display("test alarm done");
        // periodic: rising tap sets, falling tap does not
        wr(RIFC_ADDR_FMT, 32'h0000_0040);
        tap(1'b1);
        chk_pin("irq_n_per", 1'b0, rtc_irq_n);
        rchk("flags_per", RIFC_ADDR_FLAGS, 32'h0000_00C0);
        tap(1'b0);
        rchk("flags_fall", RIFC_ADDR_FLAGS, 32'h0000_0000);
        $display("test periodic done");
        // writes to flags ignored; other event during read stays
        wr(RIFC_ADDR_FMT, 32'h0000_0050);
        upd(1'b0);
        wr(RIFC_ADDR_FLAGS, 32'h0000_00FF);
        fork
            rchk("flags_race", RIFC_ADDR_FLAGS, 32'h0000_0090);
            tap(1'b1);
        join
        chk_pin("irq_n_held", 1'b0, rtc_irq_n);
        rchk("flags_next", RIFC_ADDR_FLAGS, 32'h0000_00C0);
        chk_pin("irq_n_done", 1'b1, rtc_irq_n);
        $display("test read race done");
        // sticky status, mask and the level interrupt
        wr(RIFC_ADDR_IRQ_STS, 32'h0000_0007);
        wr(RIFC_ADDR_IRQ_MASK, 32'h0000_0007);
        rchk("mask", RIFC_ADDR_IRQ_MASK, 32'h0000_0007);
        rchk("sts_clr", RIFC_ADDR_IRQ_STS, 32'h0000_0000);
        upd(1'b1);
        chk_pin("irq_on", 1'b1, irq);
        rchk("sts_set", RIFC_ADDR_IRQ_STS, 32'h0000_0003);
        wr(RIFC_ADDR_IRQ_MASK, 32'h0000_0004);
        chk_pin("irq_masked", 1'b0, irq);
        wr(RIFC_ADDR_IRQ_MASK, 32'h0000_0002);
        chk_pin("irq_unmasked", 1'b1, irq);
        wr(RIFC_ADDR_IRQ_STS, 32'h0000_0002);
        chk_pin("irq_cleared", 1'b0, irq);
        rchk("sts_left", RIFC_ADDR_IRQ_STS, 32'h0000_0001);
        $display("test status done");
        // unmapped place reads zero and ignores writes
        wr(8'h10, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h10, 32'h0000_0000);
        rchk("ctrl_kept", RIFC_ADDR_FMT, 32'h0000_0050);
        $display("test unmapped done");
        conclude();
    end
endmodule // tb
`default_nettype wire
